/* File: rtl/fnd_config.sv */
// divider and delta-sigma modulator configuration bank with clock select
// assumes the serial port decoder gives one-cycle write/read strobes on clk_sys
// Functional notes
// R1: reference divide field is 14 bits; 0 illegal, 1 bypass, else divide-by-value.
// R2: integer divide word drives the VCO divider in every mode.
// R3: software keeps integer word 36..65535 fractional, 32..65535 integer.
// R4: 24-bit fractional word applied only in fractional mode.
// R5: in fractional mode the seed register seeds the modulator.
// R6: with keying enabled the seed register is the f1 word instead.
// R7: modulator type code 2 is type 1, code 3 is type 2; 0,1 unused.
// R8: core reset bit low holds the modulator core in reset.
// R9: buffer reset bit low holds the core output buffers in reset.
// R10: software clears both resets for integer mode, only core reset with slip prevention.
// R11: bypass bit ignores modulator output while the modulator keeps clocking.
// R12: with autoseed set every fractional word write also loads the seed; the load pulse reaches the modulator only in fractional mode.
// R13: keying enable bit switches to keying mode, taking input from serial data in.
// R14: clock source bit 1 picks reference divider clock, 0 the VCO divider clock.
// R15: polarity bit set inverts the selected modulator clock.
// R16: four-bit slip correction magnitude passes out; sign chosen by slip logic.
// R17: software writes 011 to config bits 12:10 to enter fractional mode.
// R18: software adjusts charge pump leakage when fractional mode is used.
`timescale 1ns/1ps
module fnd_config (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [fnd_pkg::ADDR_W-1:0] regAddr,
	input wire logic [fnd_pkg::DATA_W-1:0] regWrData,
	output logic [fnd_pkg::DATA_W-1:0] regRdData,
	output logic regRdValid,
	input wire logic serialDataIn,
	input wire logic refDivClkIn,
	input wire logic vcoDivClkIn,
	output logic [fnd_pkg::REFDIV_W-1:0] refDivRatio,
	output logic refDivBypass,
	output logic refDivIllegal,
	output logic [fnd_pkg::INTG_W-1:0] vcoIntWord,
	output logic [fnd_pkg::FRAC_W-1:0] vcoFracWord,
	output logic fracMode,
	output logic [fnd_pkg::SEED_W-1:0] modSeedValue,
	output logic modSeedLoad,
	output logic [fnd_pkg::SEED_W-1:0] fskF1Word,
	output logic fskActive,
	output logic fskKey,
	output logic modTypeValid,
	output logic modTypeSel,
	output logic coreResetHold,
	output logic bufferResetHold,
	output logic modOutIgnore,
	output logic modClkLevel,
	output logic modClkTick,
	output logic [fnd_pkg::CSP_W-1:0] cspMagnitude
);
	import fnd_pkg::*;

	// a level is only believed once the last two stages agree
	function automatic logic syncFilter(input logic s2, input logic s3,
		input logic held);
		syncFilter = (s2 == s3) ? s3 : held;
	endfunction

	function automatic logic isWrite(input logic en,
		input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
		isWrite = en && (a == target);
	endfunction

	logic [REFDIV_W-1:0] refDiv_reg, refDiv_next;
	logic [INTG_W-1:0] intg_reg, intg_next;
	logic [FRAC_W-1:0] frac_reg, frac_next;
	logic [SEED_W-1:0] seed_reg, seed_next;
	logic [CFG_W-1:0] cfg_reg, cfg_next;
	logic seedLoad_reg, seedLoad_next;
	logic [DATA_W-1:0] rdData_reg, rdData_next;
	logic rdValid_reg, rdValid_next;

	logic [2:0] sdiSync_reg, sdiSync_next;
	logic [2:0] refSync_reg, refSync_next;
	logic [2:0] vcoSync_reg, vcoSync_next;
	logic sdiFilt_reg, sdiFilt_next;
	logic refFilt_reg, refFilt_next;
	logic vcoFilt_reg, vcoFilt_next;
	logic modLevel_reg, modLevel_next;

	logic wrRef, wrInt, wrFrac, wrSeed, wrCfg;
	logic selLevel;
	fnd_order_t order;

	assign wrRef = isWrite(regWrEn, regAddr, ADDR_REFDIV);
	assign wrInt = isWrite(regWrEn, regAddr, ADDR_INTG);
	assign wrFrac = isWrite(regWrEn, regAddr, ADDR_FRAC);
	assign wrSeed = isWrite(regWrEn, regAddr, ADDR_SEED);
	assign wrCfg = isWrite(regWrEn, regAddr, ADDR_CFG);

	always_comb begin
		refDiv_next = refDiv_reg;
		intg_next = intg_reg;
		frac_next = frac_reg;
		seed_next = seed_reg;
		cfg_next = cfg_reg;
		if (wrRef) begin
			refDiv_next = regWrData[REFDIV_W-1:0];
		end
		if (wrInt) begin
			intg_next = regWrData[INTG_W-1:0];
		end
		if (wrFrac) begin
			frac_next = regWrData[FRAC_W-1:0];
		end
		if (wrSeed) begin
			seed_next = regWrData[SEED_W-1:0];
		end
		if (wrCfg) begin
			cfg_next = regWrData[CFG_W-1:0];
		end
		// the load pulse follows the frac write so the new word and seed meet
		seedLoad_next = wrFrac && cfg_reg[CFG_AUTOSEED]; // R12
		rdValid_next = regRdEn;
		rdData_next = rdData_reg;
		if (regRdEn) begin
			if (regAddr == ADDR_REFDIV) begin
				rdData_next = {{(DATA_W-REFDIV_W){1'b0}}, refDiv_reg};
			end else if (regAddr == ADDR_INTG) begin
				rdData_next = {{(DATA_W-INTG_W){1'b0}}, intg_reg};
			end else if (regAddr == ADDR_FRAC) begin
				rdData_next = frac_reg;
			end else if (regAddr == ADDR_SEED) begin
				rdData_next = seed_reg;
			end else if (regAddr == ADDR_CFG) begin
				rdData_next = cfg_reg;
			end else begin
				rdData_next = '0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			refDiv_reg <= RST_REFDIV;
			intg_reg <= RST_INTG;
			frac_reg <= RST_FRAC;
			seed_reg <= RST_SEED;
			cfg_reg <= RST_CFG;
			seedLoad_reg <= 1'b0;
			rdData_reg <= '0;
			rdValid_reg <= 1'b0;
		end else begin
			refDiv_reg <= refDiv_next;
			intg_reg <= intg_next;
			frac_reg <= frac_next;
			seed_reg <= seed_next;
			cfg_reg <= cfg_next;
			seedLoad_reg <= seedLoad_next;
			rdData_reg <= rdData_next;
			rdValid_reg <= rdValid_next;
		end
	end

	// pin inputs: three stages, first stage feeds only the second
	always_comb begin
		sdiSync_next = {sdiSync_reg[1:0], serialDataIn};
		refSync_next = {refSync_reg[1:0], refDivClkIn};
		vcoSync_next = {vcoSync_reg[1:0], vcoDivClkIn};
		sdiFilt_next = syncFilter(sdiSync_reg[1], sdiSync_reg[2], sdiFilt_reg);
		refFilt_next = syncFilter(refSync_reg[1], refSync_reg[2], refFilt_reg);
		vcoFilt_next = syncFilter(vcoSync_reg[1], vcoSync_reg[2], vcoFilt_reg);
		modLevel_next = selLevel;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sdiSync_reg <= 3'h0;
			refSync_reg <= 3'h0;
			vcoSync_reg <= 3'h0;
			sdiFilt_reg <= 1'b0;
			refFilt_reg <= 1'b0;
			vcoFilt_reg <= 1'b0;
			// idle level equals the polarity bit, so release gives no tick
			modLevel_reg <= RST_CFG[CFG_CLK_INV];
		end else begin
			sdiSync_reg <= sdiSync_next;
			refSync_reg <= refSync_next;
			vcoSync_reg <= vcoSync_next;
			sdiFilt_reg <= sdiFilt_next;
			refFilt_reg <= refFilt_next;
			vcoFilt_reg <= vcoFilt_next;
			modLevel_reg <= modLevel_next;
		end
	end

	// divided clocks are far below clk_sys; sampling limits them to ~2.5 MHz
	assign selLevel = (cfg_reg[CFG_REFDIV_SEL] ? refFilt_reg : vcoFilt_reg) // R14
		^ cfg_reg[CFG_CLK_INV]; // R15
	assign modClkLevel = modLevel_reg;
	// clocking continues under bypass; only the core reset stops the tick
	assign modClkTick = modLevel_next && !modLevel_reg && cfg_reg[CFG_CORE_RSTN]; // R11

	assign order = fnd_order_t'(cfg_reg[CFG_ORDER_LO+1:CFG_ORDER_LO]);
	assign modTypeValid = (order == FND_ORDER_TYPE1) // R7
		|| (order == FND_ORDER_TYPE2);
	assign modTypeSel = (order == FND_ORDER_TYPE2); // R7

	assign refDivRatio = refDiv_reg; // R1
	assign refDivBypass = (refDiv_reg == REFDIV_BYPASS); // R1
	assign refDivIllegal = (refDiv_reg == REFDIV_ILLEGAL); // R1
	assign vcoIntWord = intg_reg; // R2
	assign coreResetHold = !cfg_reg[CFG_CORE_RSTN]; // R8
	assign bufferResetHold = !cfg_reg[CFG_BUF_RSTN]; // R9
	assign modOutIgnore = cfg_reg[CFG_BYPASS]; // R11
	assign fskActive = cfg_reg[CFG_FSK_EN]; // R13
	assign fskKey = fskActive && sdiFilt_reg; // R13
	assign fracMode = cfg_reg[CFG_CORE_RSTN] && cfg_reg[CFG_BUF_RSTN]
		&& !cfg_reg[CFG_BYPASS] && !fskActive;
	assign vcoFracWord = fracMode ? frac_reg : '0; // R4
	assign modSeedValue = fracMode ? seed_reg : '0; // R5
	assign modSeedLoad = seedLoad_reg && fracMode; // R12
	assign fskF1Word = fskActive ? seed_reg : '0; // R6
	assign cspMagnitude = cfg_reg[CFG_CSP_LO+CSP_W-1:CFG_CSP_LO]; // R16
	assign regRdData = rdData_reg;
	assign regRdValid = rdValid_reg;

	// checks look one edge after the strobe or level that caused it; the f1 word, tick-hold and fskKey checks look in the same cycle
	sequence s_cfgWrite;
		regWrEn && (regAddr == ADDR_CFG);
	endsequence

	sequence s_fracWrite;
		regWrEn && (regAddr == ADDR_FRAC);
	endsequence

	a_ref_bypass_decode: assert property (@(posedge clk_sys) // R1
		disable iff (!resetn)
		regWrEn && regAddr == ADDR_REFDIV |=>
		refDivBypass == ($past(regWrData[REFDIV_W-1:0]) == 14'h0001)
		&& refDivIllegal == ($past(regWrData[REFDIV_W-1:0]) == 14'h0000))
		else $error("reference divide decode wrong");
	a_ref_ratio: assert property (@(posedge clk_sys) // R1
		disable iff (!resetn)
		regWrEn && regAddr == ADDR_REFDIV |=>
		refDivRatio == $past(regWrData[REFDIV_W-1:0]))
		else $error("reference divide value not stored");
	a_int_word_follow: assert property (@(posedge clk_sys) // R2
		disable iff (!resetn)
		regWrEn && regAddr == ADDR_INTG |=>
		vcoIntWord == $past(regWrData[INTG_W-1:0]))
		else $error("integer word not applied");
	a_int_word_hold: assert property (@(posedge clk_sys) // R2
		disable iff (!resetn)
		!(regWrEn && regAddr == ADDR_INTG) |=> $stable(vcoIntWord))
		else $error("integer word changed without a write");
	a_frac_gated: assert property (@(posedge clk_sys) // R4
		disable iff (!resetn)
		s_cfgWrite ##1 !fracMode |-> vcoFracWord == 24'h000000)
		else $error("fraction applied outside fractional mode");
	a_frac_follow: assert property (@(posedge clk_sys) // R4
		disable iff (!resetn)
		s_fracWrite ##1 fracMode |-> vcoFracWord == $past(regWrData))
		else $error("fraction word not applied");
	a_seed_autoload: assert property (@(posedge clk_sys) // R12
		disable iff (!resetn)
		s_fracWrite ##0 cfg_reg[CFG_AUTOSEED] ##1 fracMode |->
		modSeedLoad && modSeedValue == seed_reg)
		else $error("autoseed did not load");
	a_seed_noload: assert property (@(posedge clk_sys) // R12
		disable iff (!resetn)
		!$past(regWrEn && regAddr == ADDR_FRAC) |-> !modSeedLoad)
		else $error("seed load without frac write");
	a_fsk_f1_word: assert property (@(posedge clk_sys) // R6
		disable iff (!resetn)
		fskActive |-> fskF1Word == seed_reg && modSeedValue == 24'h000000)
		else $error("seed not routed as f1 word");
	a_core_hold: assert property (@(posedge clk_sys) // R8
		disable iff (!resetn)
		s_cfgWrite |=> coreResetHold == !$past(regWrData[CFG_CORE_RSTN])
		&& bufferResetHold == !$past(regWrData[CFG_BUF_RSTN]))
		else $error("reset hold does not track config");
	a_tick_core_hold: assert property (@(posedge clk_sys) // R8
		disable iff (!resetn)
		coreResetHold |-> !modClkTick)
		else $error("modulator tick while core held");
	a_mod_type: assert property (@(posedge clk_sys) // R7
		disable iff (!resetn)
		s_cfgWrite |=> modTypeValid == $past(regWrData[CFG_ORDER_LO+1])
		&& modTypeSel == ($past(regWrData[9:8]) == 2'h3))
		else $error("modulator type decode wrong");
	a_type_off: assert property (@(posedge clk_sys) // R7
		disable iff (!resetn)
		s_cfgWrite ##1 !modTypeValid |-> !modTypeSel)
		else $error("unused modulator code selects a type");
	a_bypass_flag: assert property (@(posedge clk_sys) // R11
		disable iff (!resetn)
		s_cfgWrite |=> modOutIgnore == $past(regWrData[CFG_BYPASS]))
		else $error("bypass bit not applied");
	a_fsk_enable: assert property (@(posedge clk_sys) // R13
		disable iff (!resetn)
		s_cfgWrite |=> fskActive == $past(regWrData[CFG_FSK_EN]))
		else $error("keying enable not applied");
	a_fsk_key: assert property (@(posedge clk_sys) // R13
		disable iff (!resetn)
		!fskActive |-> !fskKey)
		else $error("keying input passed while disabled");
	a_clk_select: assert property (@(posedge clk_sys) // R14
		disable iff (!resetn)
		cfg_reg[CFG_REFDIV_SEL] && !cfg_reg[CFG_CLK_INV] |=>
		modClkLevel == $past(refFilt_reg))
		else $error("reference clock not selected");
	a_clk_invert: assert property (@(posedge clk_sys) // R15
		disable iff (!resetn)
		!cfg_reg[CFG_REFDIV_SEL] && cfg_reg[CFG_CLK_INV] |=>
		modClkLevel == !$past(vcoFilt_reg))
		else $error("selected clock not inverted");
	a_clk_tick: assert property (@(posedge clk_sys) // R15
		disable iff (!resetn)
		modClkTick |=> modClkLevel && !$past(modClkLevel))
		else $error("tick not on a selected clock rise");
	a_csp_magn: assert property (@(posedge clk_sys) // R16
		disable iff (!resetn)
		s_cfgWrite |=> cspMagnitude == $past(regWrData[23:20]))
		else $error("slip magnitude not applied");
endmodule

/* File: rtl/fnd_pkg.sv */
// constants for the divider and modulator configuration bank
// assumes a serial port front end that presents word-wide register strobes
package fnd_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;
	localparam int REFDIV_W = 14;
	localparam int INTG_W = 16;
	localparam int FRAC_W = 24;
	localparam int SEED_W = 24;
	localparam int CFG_W = 24;
	localparam int CSP_W = 4;

	localparam logic [ADDR_W-1:0] ADDR_REFDIV = 6'h02;
	localparam logic [ADDR_W-1:0] ADDR_INTG = 6'h03;
	localparam logic [ADDR_W-1:0] ADDR_FRAC = 6'h04;
	localparam logic [ADDR_W-1:0] ADDR_SEED = 6'h05;
	localparam logic [ADDR_W-1:0] ADDR_CFG = 6'h06;

	localparam logic [REFDIV_W-1:0] RST_REFDIV = 14'h0001;
	localparam logic [INTG_W-1:0] RST_INTG = 16'h00C8;
	localparam logic [FRAC_W-1:0] RST_FRAC = 24'h000000;
	localparam logic [SEED_W-1:0] RST_SEED = 24'h000000;
	localparam logic [CFG_W-1:0] RST_CFG = 24'h842E87;

	localparam logic [REFDIV_W-1:0] REFDIV_ILLEGAL = 14'h0000;
	localparam logic [REFDIV_W-1:0] REFDIV_BYPASS = 14'h0001;

	// configuration field positions
	localparam int CFG_ORDER_LO = 8;
	localparam int CFG_CORE_RSTN = 10;
	localparam int CFG_BUF_RSTN = 11;
	localparam int CFG_BYPASS = 12;
	localparam int CFG_AUTOSEED = 13;
	localparam int CFG_FSK_EN = 15;
	localparam int CFG_REFDIV_SEL = 17;
	localparam int CFG_CLK_INV = 18;
	localparam int CFG_CSP_LO = 20;

	typedef enum logic [1:0] {
		FND_ORDER_UNUSED0 = 2'b00,
		FND_ORDER_UNUSED1 = 2'b01,
		FND_ORDER_TYPE1 = 2'b10,
		FND_ORDER_TYPE2 = 2'b11
	} fnd_order_t;
endpackage

/* File: verif/fnd_config_test.sv */
// self-checking bench for the divider and modulator configuration bank
// assumes fnd_pkg and fnd_config are compiled ahead of this file
`timescale 1ns/1ps
module fnd_config_test;
	import fnd_pkg::*;
	logic clk_sys, resetn, regWrEn, regRdEn, serialDataIn;
	logic refDivClkIn, vcoDivClkIn, regRdValid, refDivBypass, refDivIllegal;
	logic fracMode, modSeedLoad, fskActive, fskKey, modTypeValid;
	logic modTypeSel, coreResetHold, bufferResetHold, modOutIgnore;
	logic modClkLevel, modClkTick;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData, regRdData;
	logic [REFDIV_W-1:0] refDivRatio;
	logic [INTG_W-1:0] vcoIntWord;
	logic [FRAC_W-1:0] vcoFracWord;
	logic [SEED_W-1:0] modSeedValue, fskF1Word;
	logic [CSP_W-1:0] cspMagnitude;
	logic [CFG_W-1:0] cfg;
	int fails, compares, cycles, n;
	fnd_config fnd_config_i (.clk_sys, .resetn, .regWrEn, .regRdEn, .regAddr,
		.regWrData, .regRdData, .regRdValid, .serialDataIn, .refDivClkIn,
		.vcoDivClkIn, .refDivRatio, .refDivBypass, .refDivIllegal, .vcoIntWord,
		.vcoFracWord, .fracMode, .modSeedValue, .modSeedLoad, .fskF1Word,
		.fskActive, .fskKey, .modTypeValid, .modTypeSel, .coreResetHold,
		.bufferResetHold, .modOutIgnore, .modClkLevel, .modClkTick,
		.cspMagnitude);
	initial begin
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic test_done;
		if (fails == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// generous ceiling: the whole sequence needs only a few hundred cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			test_done;
		end
	end
	task automatic chk(input string nm, input logic [23:0] seen,
		input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [23:0] d);
		@(posedge clk_sys);
		regWrEn <= 1'h1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrEn <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [23:0] exp);
		@(posedge clk_sys);
		regRdEn <= 1'h1;
		regAddr <= a;
		@(posedge clk_sys);
		regRdEn <= 1'h0;
		#1;
		chk("regRdValid", 24'(regRdValid), 24'h1);
		chk("regRdData", regRdData, exp);
	endtask
	// ref toggles every four cycles: four rising edges in the window
	task automatic pulse_ref;
		n = 0;
		for (int k = 0; k < 36; k++) begin
			@(posedge clk_sys);
			refDivClkIn <= 1'(k % 8 >= 4);
			#1;
			n += int'(modClkTick);
		end
	endtask
	task automatic t_reset;
		chk("vcoIntWord", 24'(vcoIntWord), 24'hC8);
		rd(ADDR_REFDIV, 24'h1);
		rd(ADDR_INTG, 24'hC8);
		rd(ADDR_FRAC, 24'h0);
		rd(ADDR_SEED, 24'h0);
		rd(ADDR_CFG, 24'h842E87);
		rd(6'h07, 24'h0);
	endtask
	task automatic t_refdiv;
		wr(ADDR_REFDIV, 24'h0);
		chk("refDivIllegal", 24'(refDivIllegal), 24'h1);
		wr(ADDR_REFDIV, 24'hFFFFFF);
		chk("refDivRatio", 24'(refDivRatio), 24'h3FFF);
		chk("refDivBypass", 24'(refDivBypass), 24'h0);
		rd(ADDR_REFDIV, 24'h3FFF);
		wr(ADDR_REFDIV, 24'h1);
		chk("refDivBypass", 24'(refDivBypass), 24'h1);
	endtask
	task automatic t_frac;
		wr(ADDR_SEED, 24'hA5A5A5);
		wr(ADDR_FRAC, 24'h123456);
		chk("modSeedLoad", 24'(modSeedLoad), 24'h1);
		chk("modSeedValue", modSeedValue, 24'hA5A5A5);
		chk("vcoFracWord", vcoFracWord, 24'h123456);
		@(posedge clk_sys);
		#1;
		chk("modSeedLoad", 24'(modSeedLoad), 24'h0);
		wr(ADDR_CFG, 24'h840E87);
		wr(ADDR_FRAC, 24'hFFFFFF);
		chk("modSeedLoad", 24'(modSeedLoad), 24'h0);
		wr(ADDR_CFG, 24'h841E87);
		chk("modOutIgnore", 24'(modOutIgnore), 24'h1);
		chk("vcoFracWord", vcoFracWord, 24'h0);
		wr(ADDR_INTG, 24'hFFFF);
		chk("vcoIntWord", 24'(vcoIntWord), 24'hFFFF);
	endtask
	// codes, reset bits and slip magnitude swept together
	task automatic t_cfg;
		for (int i = 0; i < 4; i++) begin
			cfg = {4'(i * 5), 20'h02087} | (24'(i) << 8) | (24'(i) << 10);
			wr(ADDR_CFG, cfg);
			chk("modTypeValid", 24'(modTypeValid), 24'(i > 1));
			chk("modTypeSel", 24'(modTypeSel), 24'(i == 3));
			chk("coreResetHold", 24'(coreResetHold), 24'(i % 2 == 0));
			chk("bufferResetHold", 24'(bufferResetHold), 24'(i < 2));
			chk("cspMagnitude", 24'(cspMagnitude), 24'(i * 5));
			// i == 3 enters fractional mode; leakage trim lives in another bank
			chk("fracMode", 24'(fracMode), 24'(i == 3));
		end
	endtask
	task automatic t_fsk;
		wr(ADDR_SEED, 24'h00BEEF);
		wr(ADDR_CFG, cfg | 24'h8000);
		chk("fskActive", 24'(fskActive), 24'h1);
		chk("fskF1Word", fskF1Word, 24'h00BEEF);
		chk("fskKey", 24'(fskKey), 24'h0);
		@(posedge clk_sys);
		serialDataIn <= 1'h1;
		repeat (6) @(posedge clk_sys);
		#1;
		chk("fskKey", 24'(fskKey), 24'h1);
		wr(ADDR_CFG, cfg);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("fskKey", 24'(fskKey), 24'h0);
		chk("fskF1Word", fskF1Word, 24'h0);
	endtask
	task automatic t_clk;
		@(posedge clk_sys);
		refDivClkIn <= 1'h1;
		for (int j = 0; j < 4; j++) begin
			wr(ADDR_CFG, cfg | (24'(j) << 17));
			repeat (6) @(posedge clk_sys);
			#1;
			chk("modClkLevel", 24'(modClkLevel), 24'(j == 1 || j == 2));
		end
		// the divided VCO path must carry a real level, not a constant
		@(posedge clk_sys);
		vcoDivClkIn <= 1'h1;
		wr(ADDR_CFG, cfg);
		repeat (6) @(posedge clk_sys);
		#1;
		chk("modClkLevel", 24'(modClkLevel), 24'h1);
		wr(ADDR_CFG, cfg | 24'h20000);
		pulse_ref;
		chk("modClkTick", 24'(n), 24'h4);
		wr(ADDR_CFG, cfg & 24'hFFFBFF | 24'h20000);
		pulse_ref;
		chk("modClkTick", 24'(n), 24'h0);
		wr(ADDR_CFG, cfg | 24'h21000);
		pulse_ref;
		chk("modClkTick", 24'(n), 24'h4);
	endtask
	// mid-run reset: registers and the tick detector return to idle
	task automatic t_rerst;
		wr(ADDR_INTG, 24'h0024);
		@(posedge clk_sys);
		resetn <= 1'h0;
		@(posedge clk_sys);
		resetn <= 1'h1;
		#1;
		chk("vcoIntWord", 24'(vcoIntWord), 24'hC8);
		chk("modClkTick", 24'(modClkTick), 24'h0);
		rd(ADDR_CFG, 24'h842E87);
	endtask
	initial begin
		resetn = 1'h0;
		regWrEn = 1'h0;
		regRdEn = 1'h0;
		regAddr = 6'h00;
		regWrData = 24'h0;
		serialDataIn = 1'h0;
		refDivClkIn = 1'h0;
		vcoDivClkIn = 1'h0;
		fails = 0;
		compares = 0;
		cycles = 0;
		repeat (5) @(posedge clk_sys);
		resetn <= 1'h1;
		#1;
		t_reset;
		t_refdiv;
		t_frac;
		t_cfg;
		t_fsk;
		t_clk;
		t_rerst;
		test_done;
	end
endmodule
